// ---- fcb_fir_coef_bank.sv ----
// channel b upper-tap coefficient bank with the nine-tap equalizer datapath
`timescale 1ns/1ps
// Overview of operation
// - taps hold 12-bit signed coefficient in bits 11:0; bits 15:12 reserved.
// - offset 0x453 supplies the sixth tap of channel b in dual channel mode.
// - offset 0x455 supplies the seventh tap of channel b in dual mode.
// - offset 0x457 supplies the eighth tap of channel b in dual mode.
// - offset 0x459 supplies the ninth, last tap of channel b in dual mode.
// - readback shows coefficient msb as zero; other bits read as written.
// - all coefficient registers, reserved bits too, clear to zero at reset.
// - fifth tap is the center tap with an 18-bit signed coefficient.
module fcb_fir_coef_bank (
  input  wire logic        clk_sys,        // 10 MHz system clock
  input  wire logic        rst_n,          // synchronous reset, active low
  input  wire logic        cfg_wr_en,      // config port write strobe
  input  wire logic        cfg_rd_en,      // config port read strobe
  input  wire logic [11:0] cfg_addr,       // config port register address
  input  wire logic [15:0] cfg_wdata,      // config port write data
  output logic      [15:0] cfg_rdata,      // config port read data
  output logic             cfg_rd_valid,   // read data valid pulse
  input  wire logic        dual_chan_mode, // device runs dual channel
  input  wire logic [47:0] coef_lower,     // taps 1..4, 12 bits each, tap1 low
  input  wire logic [17:0] coef_center,    // center tap coefficient
  input  wire logic        samp_b_valid,   // new channel b sample
  input  wire logic [11:0] samp_b,         // channel b sample, signed
  output logic      [47:0] coef_upper,     // taps 6..9 as applied, tap6 low
  output logic      [33:0] fir_out,        // filtered sample, signed
  output logic             fir_out_valid   // filtered sample valid pulse
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  localparam int unsigned PROD_W = fcb_pkg::SAMP_W + fcb_pkg::CENTER_W;
  localparam int unsigned ACC_W  = PROD_W + 4;

  if (fcb_pkg::NUM_TAPS != fcb_pkg::LOWER_TAPS + 1 + fcb_pkg::UPPER_TAPS)
  begin : g_chk_taps
    $error("tap counts do not add up to the filter length");
  end
  if (ACC_W != 34)
  begin : g_chk_acc
    $error("accumulator width does not match the output port");
  end

  // ----------------------------------------------------------------
  // coefficient registers
  // ----------------------------------------------------------------
  localparam logic [47:0] OFS_LIST = {fcb_pkg::CHAN_B_FIR_TAP9_COEF_OFS, fcb_pkg::CHAN_B_FIR_TAP8_COEF_OFS,
                                      fcb_pkg::CHAN_B_FIR_TAP7_COEF_OFS, fcb_pkg::CHAN_B_FIR_TAP6_COEF_OFS};

  logic [15:0] coef_q [fcb_pkg::UPPER_TAPS];
  logic [3:0]  hit;

  for (genvar i = 0; i < fcb_pkg::UPPER_TAPS; i++)
  begin : g_coef
    fcb_coef_reg #(
      .OFFSET (OFS_LIST[i*12 +: 12])
    ) u_coef (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .wr_en   (cfg_wr_en),
      .addr    (cfg_addr),
      .wdata   (cfg_wdata),
      .reg_q   (coef_q[i])
    );
    assign hit[i] = (cfg_addr == OFS_LIST[i*12 +: 12]);
    // only the coefficient field steers the filter; reserved bits are storage
    assign coef_upper[i*12 +: 12] = coef_q[i][fcb_pkg::COEF_MSB:fcb_pkg::COEF_LSB];
  end

  // ----------------------------------------------------------------
  // readback
  // ----------------------------------------------------------------
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;
  logic        rvld_reg;
  logic        rvld_next;

  always_comb
  begin
    rdata_next = rdata_reg;
    rvld_next  = cfg_rd_en;
    if (cfg_rd_en)
    begin
      rdata_next = 16'h0000; // unmapped offsets read zero
      for (int k = 0; k < fcb_pkg::UPPER_TAPS; k++)
      begin
        if (hit[k])
        begin
          rdata_next = coef_q[k];
        end
      end
      // known quirk kept on purpose: software tools compensate for it
      rdata_next[fcb_pkg::COEF_MSB] = 1'b0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      rdata_reg <= 16'h0000;
      rvld_reg  <= 1'b0;
    end
    else
    begin
      rdata_reg <= rdata_next;
      rvld_reg  <= rvld_next;
    end
  end

  assign cfg_rdata    = rdata_reg;
  assign cfg_rd_valid = rvld_reg;

  // ----------------------------------------------------------------
  // equalizer datapath
  // ----------------------------------------------------------------
  logic signed [11:0]        dly_reg  [fcb_pkg::NUM_TAPS-1];
  logic signed [11:0]        dly_next [fcb_pkg::NUM_TAPS-1];
  logic signed [11:0]        win      [fcb_pkg::NUM_TAPS];
  logic signed [17:0]        cf       [fcb_pkg::NUM_TAPS];
  logic signed [PROD_W-1:0]  prod     [fcb_pkg::NUM_TAPS];
  logic signed [ACC_W-1:0]   acc;
  logic        [33:0]        out_reg;
  logic        [33:0]        out_next;
  logic                      ovld_reg;
  logic                      ovld_next;

  assign win[0] = signed'(samp_b);

  for (genvar t = 0; t < fcb_pkg::NUM_TAPS; t++)
  begin : g_tap
    if (t > 0)
    begin : g_win
      assign win[t] = dly_reg[t-1];
    end
    if (t < fcb_pkg::CENTER_IDX)
    begin : g_low
      assign cf[t] = 18'(signed'(coef_lower[t*12 +: 12]));
    end
    else if (t == fcb_pkg::CENTER_IDX)
    begin : g_ctr
      assign cf[t] = signed'(coef_center);
    end
    else
    begin : g_up
      // taps six to nine come from the local registers
      assign cf[t] = 18'(signed'(coef_upper[(t-5)*12 +: 12]));
    end
    assign prod[t] = PROD_W'(win[t]) * PROD_W'(cf[t]);
  end

  always_comb
  begin
    acc = '0;
    for (int k = 0; k < fcb_pkg::NUM_TAPS; k++)
    begin
      acc = acc + ACC_W'(prod[k]);
    end
  end

  always_comb
  begin
    dly_next  = dly_reg;
    out_next  = out_reg;
    ovld_next = 1'b0;
    if (!dual_chan_mode)
    begin
      out_next = 34'h000000000; // channel b set unused outside dual mode
    end
    else if (samp_b_valid)
    begin
      dly_next[0] = win[0];
      for (int k = 1; k < fcb_pkg::NUM_TAPS-1; k++)
      begin
        dly_next[k] = dly_reg[k-1];
      end
      out_next  = acc;
      ovld_next = 1'b1;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      for (int k = 0; k < fcb_pkg::NUM_TAPS-1; k++)
      begin
        dly_reg[k] <= 12'sh000;
      end
      out_reg  <= 34'h000000000;
      ovld_reg <= 1'b0;
    end
    else
    begin
      dly_reg  <= dly_next;
      out_reg  <= out_next;
      ovld_reg <= ovld_next;
    end
  end

  assign fir_out       = out_reg;
  assign fir_out_valid = ovld_reg;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_tap6_write_apply: assert property (cfg_wr_en && cfg_addr == fcb_pkg::CHAN_B_FIR_TAP6_COEF_OFS
                                       |=> coef_upper[11:0] == $past(cfg_wdata[11:0]))
    else $error("tap6 write not applied");
  a_tap7_write_apply: assert property (cfg_wr_en && cfg_addr == fcb_pkg::CHAN_B_FIR_TAP7_COEF_OFS
                                       |=> coef_upper[23:12] == $past(cfg_wdata[11:0]))
    else $error("tap7 write not applied");
  a_tap8_write_apply: assert property (cfg_wr_en && cfg_addr == fcb_pkg::CHAN_B_FIR_TAP8_COEF_OFS
                                       |=> coef_upper[35:24] == $past(cfg_wdata[11:0]))
    else $error("tap8 write not applied");
  a_tap9_write_apply: assert property (cfg_wr_en && cfg_addr == fcb_pkg::CHAN_B_FIR_TAP9_COEF_OFS
                                       |=> coef_upper[47:36] == $past(cfg_wdata[11:0]))
    else $error("tap9 write not applied");
  a_rdback_msb_zero: assert property (cfg_rd_valid |-> cfg_rdata[11] == 1'b0)
    else $error("readback msb not zero");
  a_rdback_after_write: assert property (cfg_wr_en && cfg_addr == fcb_pkg::CHAN_B_FIR_TAP6_COEF_OFS
                                         ##1 cfg_rd_en && cfg_addr == fcb_pkg::CHAN_B_FIR_TAP6_COEF_OFS && !cfg_wr_en
                                         |=> cfg_rdata == ($past(cfg_wdata, 2) & 16'hf7ff))
    else $error("readback does not match written word");
  a_reset_clears_coef: assert property (@(posedge clk_sys) $past(!rst_n) |-> coef_upper == 48'h000000000000)
    else $error("coefficients not zero after reset");
  a_fir_out_timing: assert property (fir_out_valid == $past(samp_b_valid && dual_chan_mode))
    else $error("filter output valid mistimed");
  a_fir_idle_zero: assert property (!dual_chan_mode |=> fir_out == 34'h000000000)
    else $error("filter output not cleared outside dual mode");

  c_write_tap9: cover property (cfg_wr_en && cfg_addr == fcb_pkg::CHAN_B_FIR_TAP9_COEF_OFS);
  c_read_tap6:  cover property (cfg_rd_en && cfg_addr == fcb_pkg::CHAN_B_FIR_TAP6_COEF_OFS ##1 cfg_rd_valid);
  c_fir_run:    cover property (dual_chan_mode && samp_b_valid [*3] ##1 fir_out_valid);

endmodule

// ---- fcb_pkg.sv ----
// constants for the channel b upper-tap coefficient bank and its equalizer filter
package fcb_pkg;

  // ----------------------------------------------------------------
  // configuration port geometry
  // ----------------------------------------------------------------
  localparam int unsigned CFG_ADDR_W = 12;
  localparam int unsigned REG_W      = 16;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] CHAN_B_FIR_TAP6_COEF_OFS = 12'h453;
  localparam logic [11:0] CHAN_B_FIR_TAP7_COEF_OFS = 12'h455;
  localparam logic [11:0] CHAN_B_FIR_TAP8_COEF_OFS = 12'h457;
  localparam logic [11:0] CHAN_B_FIR_TAP9_COEF_OFS = 12'h459;

  // ----------------------------------------------------------------
  // field layout and reset values
  // ----------------------------------------------------------------
  localparam int unsigned COEF_MSB   = 11;
  localparam int unsigned COEF_LSB   = 0;
  localparam int unsigned RSVD_MSB   = 15;
  localparam int unsigned RSVD_LSB   = 12;
  localparam int unsigned COEF_W     = COEF_MSB - COEF_LSB + 1;
  localparam int unsigned CENTER_W   = 18;
  localparam logic [15:0] COEF_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // filter shape
  // ----------------------------------------------------------------
  localparam int unsigned NUM_TAPS   = 9;
  localparam int unsigned CENTER_IDX = 4;
  localparam int unsigned LOWER_TAPS = 4;
  localparam int unsigned UPPER_TAPS = 4;
  localparam int unsigned SAMP_W     = 12;

endpackage

// ---- fcb_coef_reg.sv ----
// one software-visible 16-bit coefficient register at a fixed offset
`timescale 1ns/1ps
module fcb_coef_reg #(
  parameter logic [11:0] OFFSET = 12'h000
) (
  input  wire logic        clk_sys,   // system clock
  input  wire logic        rst_n,     // synchronous reset, active low
  input  wire logic        wr_en,     // config write strobe
  input  wire logic [11:0] addr,      // config address
  input  wire logic [15:0] wdata,     // config write data
  output logic      [15:0] reg_q      // stored register value
);

  logic [15:0] val_reg;
  logic [15:0] val_next;

  always_comb
  begin
    val_next = val_reg;
    if (wr_en && (addr == OFFSET))
    begin
      val_next = wdata;  // full word stored, reserved bits included
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      val_reg <= fcb_pkg::COEF_RESET;
    else
      val_reg <= val_next;
  end

  assign reg_q = val_reg;

endmodule

// ---- fcb_fir_coef_bank_tb_top.sv ----
// self-checking testbench for the channel b upper-tap coefficient bank
`timescale 1ns/1ps
module fcb_fir_coef_bank_tb_top;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic        clk_sys        = 1'b0;
  logic        rst_n          = 1'b0;
  logic        cfg_wr_en      = 1'b0;
  logic        cfg_rd_en      = 1'b0;
  logic [11:0] cfg_addr       = 12'h000;
  logic [15:0] cfg_wdata      = 16'h0000;
  logic [15:0] cfg_rdata;
  logic        cfg_rd_valid;
  logic        dual_chan_mode = 1'b1;
  logic [47:0] coef_lower     = {12'hff5, 12'h007, 12'hffb, 12'h003};
  logic [17:0] coef_center    = 18'h20005;
  logic        samp_b_valid   = 1'b0;
  logic [11:0] samp_b         = 12'h000;
  logic [47:0] coef_upper;
  logic [33:0] fir_out;
  logic        fir_out_valid;
  int          errors         = 0;
  int          comparisons    = 0;
  int          cycles         = 0;
  int          hist[9]        = '{default: 0};
  // taps 1..9 as signed integers, matching coef_lower, coef_center and the writes below
  int          coef[9]        = '{3, -5, 7, -11, -131067, -2047, 291, 2047, -1};
  localparam int          MAX_CYCLES = 500;
  localparam logic [11:0] TAP_OFS[4] = '{fcb_pkg::CHAN_B_FIR_TAP6_COEF_OFS, fcb_pkg::CHAN_B_FIR_TAP7_COEF_OFS,
                                         fcb_pkg::CHAN_B_FIR_TAP8_COEF_OFS, fcb_pkg::CHAN_B_FIR_TAP9_COEF_OFS};
  localparam logic [15:0] WDATA[4]   = '{16'hf801, 16'h0123, 16'ha7ff, 16'h0fff};

  fcb_fir_coef_bank i_dut (
    .clk_sys        (clk_sys),
    .rst_n          (rst_n),
    .cfg_wr_en      (cfg_wr_en),
    .cfg_rd_en      (cfg_rd_en),
    .cfg_addr       (cfg_addr),
    .cfg_wdata      (cfg_wdata),
    .cfg_rdata      (cfg_rdata),
    .cfg_rd_valid   (cfg_rd_valid),
    .dual_chan_mode (dual_chan_mode),
    .coef_lower     (coef_lower),
    .coef_center    (coef_center),
    .samp_b_valid   (samp_b_valid),
    .samp_b         (samp_b),
    .coef_upper     (coef_upper),
    .fir_out        (fir_out),
    .fir_out_valid  (fir_out_valid)
  );

  initial
  begin
    forever #50 clk_sys = ~clk_sys;
  end

  // ----------------------------------------------------------------
  // shared tasks; each starts and ends 1 ns after a rising edge
  // ----------------------------------------------------------------
  task automatic end_sim();
    $display("counts: %0d comparisons, %0d errors", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // strobes are left up so writes and reads can run back to back
  task automatic wr(input logic [11:0] addr, input logic [15:0] data);
    cfg_rd_en = 1'b0;
    cfg_wr_en = 1'b1;
    cfg_addr  = addr;
    cfg_wdata = data;
    @(posedge clk_sys);
    #1;
  endtask

  task automatic rd(input logic [11:0] addr, input logic [15:0] exp);
    cfg_wr_en = 1'b0;
    cfg_rd_en = 1'b1;
    cfg_addr  = addr;
    @(posedge clk_sys);
    #1;
    chk({47'h0, cfg_rd_valid}, 48'h1);
    chk({32'h0, cfg_rdata}, {32'h0, exp});
  endtask

  task automatic idle();
    cfg_wr_en = 1'b0;
    cfg_rd_en = 1'b0;
    @(posedge clk_sys);
    #1;
  endtask

  // one sample taken at the next edge; filter answer registered at that same edge and checked 1 ns later
  task automatic send(input int v);
    logic signed [47:0] e;
    samp_b       = v[11:0];
    samp_b_valid = 1'b1;
    @(posedge clk_sys);
    #1;
    for (int i = 8; i > 0; i--)
      hist[i] = hist[i-1];
    hist[0] = v;
    e = '0;
    for (int i = 0; i < 9; i++)
      e += hist[i] * coef[i];
    chk({47'h0, fir_out_valid}, 48'h1);
    chk({14'h0, fir_out}, {14'h0, e[33:0]});
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic test_reset_vals();
    for (int i = 0; i < 4; i++)
      rd(TAP_OFS[i], 16'h0000);
    idle();
    chk(coef_upper, 48'h0);
    chk({14'h0, fir_out}, 48'h0);
    $display("test reset values done");
  endtask

  task automatic test_regs();
    for (int i = 0; i < 4; i++)
      wr(TAP_OFS[i], WDATA[i]);
    wr(12'h454, 16'hffff);
    for (int i = 0; i < 4; i++)
      rd(TAP_OFS[i], WDATA[i] & 16'hf7ff);
    rd(12'h454, 16'h0000);
    // rewrite tap6 with new reserved bits only, read back at once
    wr(TAP_OFS[0], 16'h3801);
    rd(TAP_OFS[0], 16'h3001);
    idle();
    chk({47'h0, cfg_rd_valid}, 48'h0);
    chk(coef_upper, {12'hfff, 12'h7ff, 12'h123, 12'h801});
    $display("test register access done");
  endtask

  task automatic test_filter();
    for (int k = 0; k < 12; k++)
      send(k * 301 - 1500);
    // outside dual mode the sample is ignored and the output clears
    dual_chan_mode = 1'b0;
    samp_b         = 12'h005;
    @(posedge clk_sys);
    #1;
    chk({47'h0, fir_out_valid}, 48'h0);
    chk({14'h0, fir_out}, 48'h0);
    dual_chan_mode = 1'b1;
    send(-2048);
    samp_b_valid = 1'b0;
    $display("test filter done");
  endtask

  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == MAX_CYCLES)
    begin
      errors++;
      end_sim();
    end
  end

  initial
  begin
    repeat (2) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    test_reset_vals();
    test_regs();
    test_filter();
    // mid-run reset must clear every coefficient again
    rst_n = 1'b0;
    @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    test_reset_vals();
    end_sim();
  end
endmodule
